// ### rtl/fieldbus_master_state_control.sv
// Functional notes
// - At power-on, invalid stored network configuration raises event and config error flag.
// - A communications controller hardware fault raises event and port hardware flag.
// - Exactly four control states, Init to Operational, govern all permissions.
// - Start-up advances Init, Pre-Op, Safe-Op, Operational with no state skipped.
// - While running, errors move the state automatically without software command.
// - Init blocks process data and parameter access, RUN indicator off.
// - Stay in Init while no network configuration is present.
// - Pre-Op allows parameter access only, flashes RUN, leaves after network setup.
// - Safe-Op allows parameters and inputs only, flashes RUN, precedes Operational.
// - Operational allows full process data and parameters, RUN lit steadily.
// - Process data every control cycle; parameter transfers fill the gaps.
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module fieldbus_master_state_control #(
  parameter int FLASH_HALF = fieldbus_state_pkg::FLASH_HALF_CYCLES,
  parameter int CYCLE_LEN  = fieldbus_state_pkg::CYCLE_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Power-on diagnosis inputs from the port hardware
  input  wire logic        mac_fault,
  input  wire logic        port_hw_fault,
  // Link condition from the port
  input  wire logic        link_error,
  // Outputs
  output logic             net_config_error_flag,
  output logic             station_mac_error_flag,
  output logic             port_hardware_error_flag,
  output logic             event_valid,
  output logic      [31:0] event_code,
  output logic      [2:0]  state_number,
  output logic             pdo_input_enable,
  output logic             pdo_output_enable,
  output logic             sdo_enable,
  output logic             pdo_slot,
  output logic             sdo_slot,
  output logic             run_led
);

  // Pin input synchronisers
  logic [1:0] mac_sync_q;
  logic [1:0] hw_sync_q;
  logic [1:0] link_sync_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mac_sync_q  <= 2'b00;
      hw_sync_q   <= 2'b00;
      link_sync_q <= 2'b00;
    end else if (ce) begin
      mac_sync_q  <= {mac_sync_q[0], mac_fault};
      hw_sync_q   <= {hw_sync_q[0], port_hw_fault};
      link_sync_q <= {link_sync_q[0], link_error};
    end
  end

  wire mac_bad  = mac_sync_q[1];
  wire hw_bad   = hw_sync_q[1];
  wire link_bad = link_sync_q[1];

  // Registers
  logic [31:0]                           ctrl_q;
  logic [2:0]                            err_q;
  logic [fieldbus_state_pkg::SLAVE_COUNT-1:0] mbx_table_q;
  logic [fieldbus_state_pkg::SLAVE_COUNT-1:0] pd_table_q;
  fieldbus_state_pkg::comm_state_e       state_q;
  fieldbus_state_pkg::comm_state_e       state_d;
  logic [31:0]                           diag_cnt_q;
  logic [31:0]                           cyc_cnt_q;
  logic                                  evt_valid_q;
  logic [31:0]                           evt_code_q;
  logic [1:0]                            evt_pending_q;

  // AHB address phase capture
  logic        dp_valid_q;
  logic        dp_write_q;
  logic [7:0]  dp_addr_q;
  logic [31:0] hrdata_q;

  wire addr_phase = hsel && hready && htrans[1];
  wire wr_ctrl    = dp_valid_q && dp_write_q &&
                    (dp_addr_q == fieldbus_state_pkg::CTRL_OFFSET);
  wire wr_mbx     = dp_valid_q && dp_write_q &&
                    (dp_addr_q == fieldbus_state_pkg::MBX_TABLE_OFFSET);
  wire wr_pd      = dp_valid_q && dp_write_q &&
                    (dp_addr_q == fieldbus_state_pkg::PD_TABLE_OFFSET);
  wire [31:0] ctrl_wdata = hwdata & 32'h0000_000F;

  wire cfg_valid   = ctrl_q[fieldbus_state_pkg::CTRL_CFG_VALID_BIT];
  wire cfg_present = ctrl_q[fieldbus_state_pkg::CTRL_CFG_PRESENT_BIT];
  wire net_setup   = ctrl_q[fieldbus_state_pkg::CTRL_NET_SETUP_BIT];
  wire go_op       = ctrl_q[fieldbus_state_pkg::CTRL_GO_OP_BIT];
  wire err_clear   = wr_ctrl && hwdata[fieldbus_state_pkg::CTRL_ERR_CLEAR_BIT];
  wire any_err     = |err_q;
  wire diag_done   = (diag_cnt_q == 32'(fieldbus_state_pkg::DIAG_CYCLES - 1));
  wire in_diag     = (state_q == fieldbus_state_pkg::ST_DIAG);

  // Diagnosis findings, sampled on the last diagnosis cycle
  wire find_cfg = in_diag && diag_done && cfg_present && !cfg_valid;
  wire find_mac = in_diag && diag_done && mac_bad;
  wire find_hw  = in_diag && diag_done && hw_bad;

  // Read data selection
  wire [2:0]  state_number_w;
  wire [31:0] status_word = {29'h0000_0000, state_number_w};
  wire [31:0] rd_mux =
    (haddr[7:0] == fieldbus_state_pkg::CTRL_OFFSET)      ? ctrl_q :
    (haddr[7:0] == fieldbus_state_pkg::STATUS_OFFSET)    ? status_word :
    (haddr[7:0] == fieldbus_state_pkg::ERROR_OFFSET)     ? {29'h0000_0000, err_q} :
    (haddr[7:0] == fieldbus_state_pkg::MBX_TABLE_OFFSET) ? {16'h0000, mbx_table_q} :
    (haddr[7:0] == fieldbus_state_pkg::PD_TABLE_OFFSET)  ? {16'h0000, pd_table_q} :
    32'h0000_0000;

  // Bus data phase tracking; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q  <= 8'h00;
      hrdata_q   <= 32'h0000_0000;
    end else if (ce) begin
      dp_valid_q <= addr_phase;
      dp_write_q <= hwrite;
      dp_addr_q  <= haddr[7:0];
      if (addr_phase && !hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // Control register and slave ready tables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q      <= fieldbus_state_pkg::CTRL_RESET;
      mbx_table_q <= '0;
      pd_table_q  <= '0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_wdata;
      end
      if (wr_mbx) begin
        mbx_table_q <= hwdata[fieldbus_state_pkg::SLAVE_COUNT-1:0];
      end
      if (wr_pd) begin
        pd_table_q <= hwdata[fieldbus_state_pkg::SLAVE_COUNT-1:0];
      end
    end
  end

  // Sticky error flags; a new finding wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_q <= 3'b000;
    end else if (ce) begin
      err_q[fieldbus_state_pkg::ERR_NET_CFG_BIT] <= find_cfg ||
        (err_q[fieldbus_state_pkg::ERR_NET_CFG_BIT] && !err_clear);
      err_q[fieldbus_state_pkg::ERR_MAC_BIT] <= find_mac ||
        (err_q[fieldbus_state_pkg::ERR_MAC_BIT] && !err_clear);
      err_q[fieldbus_state_pkg::ERR_PORT_HW_BIT] <= find_hw ||
        (err_q[fieldbus_state_pkg::ERR_PORT_HW_BIT] && !err_clear);
    end
  end

  // Event strobes, one per finding, issued on successive cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_valid_q   <= 1'b0;
      evt_code_q    <= 32'h0000_0000;
      evt_pending_q <= 2'b00;
    end else if (ce) begin
      evt_valid_q <= 1'b0;
      if (find_cfg) begin
        evt_valid_q   <= 1'b1;
        evt_code_q    <= fieldbus_state_pkg::EVT_NET_CFG;
        evt_pending_q <= {find_hw, find_mac};
      end else if (find_mac) begin
        evt_valid_q   <= 1'b1;
        evt_code_q    <= fieldbus_state_pkg::EVT_MAC;
        evt_pending_q <= {find_hw, 1'b0};
      end else if (find_hw) begin
        evt_valid_q   <= 1'b1;
        evt_code_q    <= fieldbus_state_pkg::EVT_PORT_HW;
        evt_pending_q <= 2'b00;
      end else if (evt_pending_q[0]) begin
        evt_valid_q      <= 1'b1;
        evt_code_q       <= fieldbus_state_pkg::EVT_MAC;
        evt_pending_q[0] <= 1'b0;
      end else if (evt_pending_q[1]) begin
        evt_valid_q      <= 1'b1;
        evt_code_q       <= fieldbus_state_pkg::EVT_PORT_HW;
        evt_pending_q[1] <= 1'b0;
      end
    end
  end

  // Diagnosis timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diag_cnt_q <= 32'h0000_0000;
    end else if (ce && in_diag && !diag_done) begin
      diag_cnt_q <= diag_cnt_q + 32'h0000_0001;
    end
  end

  // Next control state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fieldbus_state_pkg::ST_DIAG: begin
        if (diag_done) begin
          state_d = fieldbus_state_pkg::ST_INIT;
        end
      end
      fieldbus_state_pkg::ST_INIT: begin
        if (cfg_present && cfg_valid && !any_err) begin
          state_d = fieldbus_state_pkg::ST_PREOP;
        end
      end
      fieldbus_state_pkg::ST_PREOP: begin
        if (!cfg_present || any_err) begin
          state_d = fieldbus_state_pkg::ST_INIT;
        end else if (net_setup) begin
          state_d = fieldbus_state_pkg::ST_SAFEOP;
        end
      end
      fieldbus_state_pkg::ST_SAFEOP: begin
        if (!cfg_present || any_err) begin
          state_d = fieldbus_state_pkg::ST_INIT;
        end else if (link_bad || !net_setup) begin
          state_d = fieldbus_state_pkg::ST_PREOP;
        end else if (go_op) begin
          state_d = fieldbus_state_pkg::ST_OP;
        end
      end
      fieldbus_state_pkg::ST_OP: begin
        if (!cfg_present || any_err) begin
          state_d = fieldbus_state_pkg::ST_INIT;
        end else if (link_bad || !go_op) begin
          state_d = fieldbus_state_pkg::ST_SAFEOP;
        end
      end
      default: begin
        state_d = fieldbus_state_pkg::ST_INIT;
      end
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= fieldbus_state_pkg::ST_DIAG;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // State number seen by software, 0 while diagnosing
  assign state_number_w =
    (state_q == fieldbus_state_pkg::ST_INIT)   ? 3'h1 :
    (state_q == fieldbus_state_pkg::ST_PREOP)  ? 3'h2 :
    (state_q == fieldbus_state_pkg::ST_SAFEOP) ? 3'h3 :
    (state_q == fieldbus_state_pkg::ST_OP)     ? 3'h4 : 3'h0;

  // Permissions per state
  wire perm_sdo = (state_q == fieldbus_state_pkg::ST_PREOP) ||
                  (state_q == fieldbus_state_pkg::ST_SAFEOP) ||
                  (state_q == fieldbus_state_pkg::ST_OP);
  wire perm_in  = (state_q == fieldbus_state_pkg::ST_SAFEOP) ||
                  (state_q == fieldbus_state_pkg::ST_OP);
  wire perm_out = (state_q == fieldbus_state_pkg::ST_OP);
  wire flashing = (state_q == fieldbus_state_pkg::ST_PREOP) ||
                  (state_q == fieldbus_state_pkg::ST_SAFEOP);

  // Control cycle timer: process data slot first, then the gap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_cnt_q <= 32'h0000_0000;
    end else if (ce) begin
      if (cyc_cnt_q == 32'(CYCLE_LEN - 1)) begin
        cyc_cnt_q <= 32'h0000_0000;
      end else begin
        cyc_cnt_q <= cyc_cnt_q + 32'h0000_0001;
      end
    end
  end

  wire in_pdo_window = cyc_cnt_q < 32'(fieldbus_state_pkg::PDO_SLOT_CYCLES);

  wire blink;

  run_flasher #(
    .HALF_CYCLES (FLASH_HALF)
  ) u_flasher (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .enable  (flashing),
    .blink   (blink)
  );

  // Registered outputs
  logic [2:0] state_num_q;
  logic       pdo_in_q;
  logic       pdo_out_q;
  logic       sdo_q;
  logic       pdo_slot_q;
  logic       sdo_slot_q;
  logic       led_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_num_q <= 3'h0;
      pdo_in_q    <= 1'b0;
      pdo_out_q   <= 1'b0;
      sdo_q       <= 1'b0;
      pdo_slot_q  <= 1'b0;
      sdo_slot_q  <= 1'b0;
      led_q       <= 1'b0;
    end else if (ce) begin
      state_num_q <= state_number_w;
      pdo_in_q    <= perm_in;
      pdo_out_q   <= perm_out;
      sdo_q       <= perm_sdo;
      pdo_slot_q  <= perm_in && in_pdo_window;
      sdo_slot_q  <= perm_sdo && !in_pdo_window;
      led_q       <= perm_out || (flashing && blink);
    end
  end

  assign hrdata                   = hrdata_q;
  assign hreadyout                = 1'b1;
  assign hresp                    = 1'b0;
  assign net_config_error_flag    = err_q[fieldbus_state_pkg::ERR_NET_CFG_BIT];
  assign station_mac_error_flag   = err_q[fieldbus_state_pkg::ERR_MAC_BIT];
  assign port_hardware_error_flag = err_q[fieldbus_state_pkg::ERR_PORT_HW_BIT];
  assign event_valid              = evt_valid_q;
  assign event_code               = evt_code_q;
  assign state_number             = state_num_q;
  assign pdo_input_enable         = pdo_in_q;
  assign pdo_output_enable        = pdo_out_q;
  assign sdo_enable               = sdo_q;
  assign pdo_slot                 = pdo_slot_q;
  assign sdo_slot                 = sdo_slot_q;
  assign run_led                  = led_q;

endmodule : fieldbus_master_state_control

// ### inc/fieldbus_state_pkg.sv
package fieldbus_state_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET      = 8'h00;
  localparam logic [7:0] STATUS_OFFSET    = 8'h04;
  localparam logic [7:0] ERROR_OFFSET     = 8'h08;
  localparam logic [7:0] MBX_TABLE_OFFSET = 8'h0C;
  localparam logic [7:0] PD_TABLE_OFFSET  = 8'h10;

  // Control register fields
  localparam int CTRL_CFG_VALID_BIT  = 0;
  localparam int CTRL_CFG_PRESENT_BIT = 1;
  localparam int CTRL_NET_SETUP_BIT  = 2;
  localparam int CTRL_GO_OP_BIT      = 3;
  localparam int CTRL_ERR_CLEAR_BIT  = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Error register fields
  localparam int ERR_NET_CFG_BIT = 0;
  localparam int ERR_MAC_BIT     = 1;
  localparam int ERR_PORT_HW_BIT = 2;

  // Number of slave positions tracked
  localparam int SLAVE_COUNT = 16;

  // Power-on diagnosis time
  localparam int DIAG_TIME_US    = 100;
  localparam int CLK_MHZ         = 10;
  localparam int DIAG_CYCLES     = DIAG_TIME_US * CLK_MHZ;

  // Flash half period of the RUN indicator
  localparam int FLASH_HALF_MS     = 200;
  localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * 1000 * CLK_MHZ;

  // Control cycle period and process-data slot length
  localparam int CYCLE_TIME_US  = 100;
  localparam int CYCLE_CYCLES   = CYCLE_TIME_US * CLK_MHZ;
  localparam int PDO_SLOT_CYCLES = 100;

  // Event codes presented with the event strobe
  localparam logic [31:0] EVT_NET_CFG = 32'h3440_0000;
  localparam logic [31:0] EVT_MAC     = 32'h1440_0000;
  localparam logic [31:0] EVT_PORT_HW = 32'h0440_0000;

  // Diagnosis state numbered zero, then communication control states numbered one to four
  typedef enum logic [2:0] {
    ST_DIAG,
    ST_INIT,
    ST_PREOP,
    ST_SAFEOP,
    ST_OP
  } comm_state_e;

endpackage : fieldbus_state_pkg

// ### rtl/run_flasher.sv
`timescale 1ns/1ps
module run_flasher #(
  parameter int HALF_CYCLES = fieldbus_state_pkg::FLASH_HALF_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic enable,
  output logic      blink
);

  logic [31:0] count_q;
  logic        blink_q;

  // Equal on and off halves; restarts dark when disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= 32'h0000_0000;
      blink_q <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        count_q <= 32'h0000_0000;
        blink_q <= 1'b0;
      end else if (count_q == 32'(HALF_CYCLES - 1)) begin
        count_q <= 32'h0000_0000;
        blink_q <= ~blink_q;
      end else begin
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  assign blink = blink_q;

endmodule : run_flasher

// ### test/fieldbus_props.sv
`timescale 1ns/1ps
module fieldbus_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        link_error,
  input wire logic        event_valid,
  input wire logic [31:0] event_code,
  input wire logic        net_config_error_flag,
  input wire logic        station_mac_error_flag,
  input wire logic        port_hardware_error_flag,
  input wire logic [2:0]  state_number,
  input wire logic        pdo_input_enable,
  input wire logic        pdo_output_enable,
  input wire logic        sdo_enable,
  input wire logic        pdo_slot,
  input wire logic        sdo_slot,
  input wire logic        run_led
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Flashing states of the RUN indicator
  wire logic flash = (state_number == 3'h2) || (state_number == 3'h3);

  // State number stays in the five legal codes and climbs one step at a time
  a_state_range: assert property (
    state_number <= 3'h4) else $error("state number out of range");
  a_no_skip: assert property (
    state_number > $past(state_number) |-> state_number == $past(state_number) + 3'h1)
    else $error("state skipped upward");
  // Permissions and indicator per state
  a_init_blocks: assert property (
    state_number == 3'h1 |-> !pdo_input_enable && !pdo_output_enable && !sdo_enable && !run_led)
    else $error("init permissions wrong");
  a_preop_sdo: assert property (
    state_number == 3'h2 |-> sdo_enable && !pdo_input_enable && !pdo_output_enable)
    else $error("preop permissions wrong");
  a_safeop_inputs: assert property (
    state_number == 3'h3 |-> sdo_enable && pdo_input_enable && !pdo_output_enable)
    else $error("safeop permissions wrong");
  a_op_full: assert property (
    state_number == 3'h4 |-> sdo_enable && pdo_input_enable && pdo_output_enable && run_led)
    else $error("op permissions wrong");
  a_flash_moves: assert property (
    not (flash && ce && $stable(run_led))[*6]) else $error("run indicator not flashing");
  // Diagnosis events leave their flag behind
  a_netcfg_flag: assert property (
    event_valid && event_code == fieldbus_state_pkg::EVT_NET_CFG
    |-> ##[0:2] net_config_error_flag)
    else $error("config flag missing");
  a_mac_flag: assert property (
    event_valid && event_code == fieldbus_state_pkg::EVT_MAC
    |-> ##[0:2] station_mac_error_flag)
    else $error("mac flag missing");
  a_hw_flag: assert property (
    event_valid && event_code == fieldbus_state_pkg::EVT_PORT_HW
    |-> ##[0:2] port_hardware_error_flag)
    else $error("port hardware flag missing");
  a_link_drop: assert property (
    $rose(link_error) && state_number == 3'h4 |-> ##[1:8] state_number == 3'h3)
    else $error("no fall back on link loss");
  a_slot_split: assert property (
    (pdo_slot |-> pdo_input_enable && !sdo_slot) and (sdo_slot |-> sdo_enable))
    else $error("slot outside permission");
endmodule : fieldbus_props

bind fieldbus_master_state_control fieldbus_props fieldbus_props_inst (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .link_error(link_error), .event_valid(event_valid),
  .event_code(event_code), .net_config_error_flag(net_config_error_flag),
  .station_mac_error_flag(station_mac_error_flag),
  .port_hardware_error_flag(port_hardware_error_flag), .state_number(state_number),
  .pdo_input_enable(pdo_input_enable), .pdo_output_enable(pdo_output_enable),
  .sdo_enable(sdo_enable), .pdo_slot(pdo_slot), .sdo_slot(sdo_slot), .run_led(run_led));

// ### test/slave_chain_model.sv
`timescale 1ns/1ps
module slave_chain_model (
  input  wire logic hclk,
  input  wire logic mac_bad,
  input  wire logic hw_bad,
  input  wire logic link_break,
  output logic      mac_fault = 1'b0,
  output logic      port_hw_fault = 1'b0,
  output logic      link_error = 1'b0
);
  // Port faults and link loss seen from the cable side, changed only on command
  always @(posedge hclk) begin
    mac_fault     <= mac_bad;
    port_hw_fault <= hw_bad;
    link_error    <= link_break;
  end
endmodule : slave_chain_model

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        mac_bad = 1'b0;
  logic        hw_bad = 1'b0;
  logic        link_break = 1'b0;
  logic        mac_fault, port_hw_fault, link_error, hreadyout, hresp, event_valid;
  logic        cfg_f, mac_f, hw_f, pin_en, pout_en, sdo_en, pdo_slot, sdo_slot, run_led;
  logic [31:0] hrdata, event_code, rd;
  logic [2:0]  state_number;
  logic [31:0] ev [3];
  logic        prev;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          n, tg, ts;

  always #50 hclk = ~hclk;

  // Design under test with short flash and control-cycle counts
  fieldbus_master_state_control #(.FLASH_HALF(4), .CYCLE_LEN(200))
      fieldbus_master_state_control_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mac_fault(mac_fault),
    .port_hw_fault(port_hw_fault), .link_error(link_error),
    .net_config_error_flag(cfg_f), .station_mac_error_flag(mac_f),
    .port_hardware_error_flag(hw_f), .event_valid(event_valid), .event_code(event_code),
    .state_number(state_number), .pdo_input_enable(pin_en), .pdo_output_enable(pout_en),
    .sdo_enable(sdo_en), .pdo_slot(pdo_slot), .sdo_slot(sdo_slot), .run_led(run_led));

  // Far side of the port
  slave_chain_model slave_chain_model_inst (
    .hclk(hclk), .mac_bad(mac_bad), .hw_bad(hw_bad), .link_break(link_break),
    .mac_fault(mac_fault), .port_hw_fault(port_hw_fault), .link_error(link_error));

  task end_of_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Single AHB-Lite transfer: address phase, then data phase
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask : rdchk

  task wait_st(input logic [2:0] s);
    int i;
    i = 0;
    @(negedge hclk);
    while (state_number !== s && i < 1200) begin
      @(negedge hclk);
      i++;
    end
    chk("state_number", {29'h0000_0000, s}, {29'h0000_0000, state_number});
  endtask : wait_st

  task perm(input logic [2:0] e);
    chk("permissions", {29'h0000_0000, e}, {29'h0000_0000, pin_en, pout_en, sdo_en});
  endtask : perm

  // Hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("ctrl", fieldbus_state_pkg::CTRL_OFFSET, 32'h0000_0000);
    rdchk("unmapped", 8'h40, 32'h0000_0000);
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    wait_st(3'h1);
    perm(3'h0);
    chk("run_led", 32'h0000_0000, {31'h0000_0000, run_led});
    repeat (50) @(negedge hclk);
    wait_st(3'h1);
    rdchk("status", fieldbus_state_pkg::STATUS_OFFSET, 32'h0000_0001);
    bus(1'b1, fieldbus_state_pkg::MBX_TABLE_OFFSET, 32'hFFFF_FFFF);
    rdchk("mbx_table", fieldbus_state_pkg::MBX_TABLE_OFFSET, 32'h0000_FFFF);
    bus(1'b1, fieldbus_state_pkg::PD_TABLE_OFFSET, 32'h1234_A5A5);
    rdchk("pd_table", fieldbus_state_pkg::PD_TABLE_OFFSET, 32'h0000_A5A5);
    // All start-up conditions at once: the states must still be walked in order
    bus(1'b1, fieldbus_state_pkg::CTRL_OFFSET, 32'h0000_000F);
    wait_st(3'h2);
    wait_st(3'h3);
    wait_st(3'h4);
    perm(3'h7);
    repeat (10) @(negedge hclk);
    chk("run_led", 32'h0000_0001, {31'h0000_0000, run_led});
    tg = 0;
    ts = 0;
    repeat (200) begin
      @(negedge hclk);
      tg += (pdo_slot === 1'b1);
      ts += (sdo_slot === 1'b1);
    end
    chk("pdo_slots", 32'h0000_0064, tg);
    chk("sdo_slots", 32'h0000_0064, ts);
    @(posedge hclk);
    link_break <= 1'b1;
    wait_st(3'h3);
    perm(3'h5);
    @(posedge hclk);
    link_break <= 1'b0;
    wait_st(3'h4);
    bus(1'b1, fieldbus_state_pkg::CTRL_OFFSET, 32'h0000_0001);
    wait_st(3'h1);
    // Second reset with port faults and a config marked present but invalid
    @(posedge hclk);
    hresetn <= 1'b0;
    mac_bad <= 1'b1;
    hw_bad  <= 1'b1;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, fieldbus_state_pkg::CTRL_OFFSET, 32'h0000_0002);
    n = 0;
    repeat (1200) begin
      @(negedge hclk);
      if (event_valid === 1'b1 && n < 3) begin
        ev[n] = event_code;
        n++;
      end
    end
    chk("event_0", fieldbus_state_pkg::EVT_NET_CFG, ev[0]);
    chk("event_1", fieldbus_state_pkg::EVT_MAC, ev[1]);
    chk("event_2", fieldbus_state_pkg::EVT_PORT_HW, ev[2]);
    rdchk("error", fieldbus_state_pkg::ERROR_OFFSET, 32'h0000_0007);
    wait_st(3'h1);
    @(posedge hclk);
    mac_bad <= 1'b0;
    hw_bad  <= 1'b0;
    bus(1'b1, fieldbus_state_pkg::CTRL_OFFSET, 32'h0000_0013);
    wait_st(3'h2);
    perm(3'h1);
    chk("flags", 32'h0000_0000, {29'h0000_0000, cfg_f, mac_f, hw_f});
    repeat (8) @(negedge hclk);
    prev = run_led;
    tg = 0;
    repeat (16) begin
      @(negedge hclk);
      tg += (run_led !== prev);
      prev = run_led;
    end
    chk("run_toggles", 32'h0000_0004, tg);
    // Clock enable low must freeze the flashing indicator and the state
    @(posedge hclk);
    ce <= 1'b0;
    @(negedge hclk);
    prev = run_led;
    tg = 0;
    repeat (12) begin
      @(negedge hclk);
      tg += (run_led !== prev);
    end
    chk("frozen_toggles", 32'h0000_0000, tg);
    chk("frozen_state", 32'h0000_0002, {29'h0000_0000, state_number});
    @(posedge hclk);
    ce <= 1'b1;
    end_of_test();
  end
endmodule : tb
